/* File: bench/iam_bus_model.sv */
/*
 * bus-side event model: address strobe, one data event, stop.
 * assumes the block samples these on rising mclk edges.
 */
`timescale 1ns/100ps
`default_nettype none
module iam_bus_model (
    input  wire logic  mclk,
    output logic       addr_strobe,
    output logic [9:0] addr_in,
    output logic       rx_byte_done,
    output logic       tx_buf_empty,
    output logic       frame_end
);
    initial begin
        {addr_strobe, rx_byte_done, tx_buf_empty, frame_end} = 4'h0;
        addr_in = 10'h000;
    end
    // address inverted off the strobe so a stale value never looks valid
    task automatic frame(input logic [9:0] a, input logic tx);
        @(posedge mclk) begin addr_strobe <= 1'b1; addr_in <= a; end
        @(posedge mclk) begin addr_strobe <= 1'b0; addr_in <= ~a; tx_buf_empty <= tx;
            rx_byte_done <= !tx; end
        @(posedge mclk) begin tx_buf_empty <= 1'b0; rx_byte_done <= 1'b0; frame_end <= 1'b1; end
        @(posedge mclk) frame_end <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: bench/iam_regs_chk_sva.sv */
/*
 * port-level checker for iam_regs: bus handshake, flags, match gating.
 * assumes it is bound to iam_regs from the bench top.
 */
`timescale 1ns/100ps
`default_nettype none
module iam_regs_chk (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    input wire logic        rx_byte_done,
    input wire logic        tx_buf_empty,
    input wire logic        addr_match,
    input wire logic        target_tx_valid,
    input wire logic        module_soft_reset,
    input wire logic        rx_flag_three,
    input wire logic        tx_flag_three
);
    wire req = avs_read | avs_write;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_wait_first: assert property (!req ##1 req |-> avs_waitrequest)
        else $error("no wait cycle on new request");
    a_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait longer than one cycle");
    a_upper_zero: assert property (avs_read && !avs_waitrequest
        |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_unmapped_resp: assert property (avs_read && !avs_waitrequest && avs_address > 8'h20
        |-> avs_response == 2'b11 && avs_readdata == 32'h0)
        else $error("unmapped read not refused");
    a_match_gate: assert property (module_soft_reset || target_tx_valid
        |-> !addr_match)
        else $error("match outside slave operation");
    a_rx_cause: assert property ($rose(rx_flag_three) |-> $past(rx_byte_done))
        else $error("rx flag without byte");
    a_tx_cause: assert property ($rose(tx_flag_three) |-> $past(tx_buf_empty))
        else $error("tx flag without empty buffer");
    a_rx_sticky: assert property (rx_flag_three && !avs_write |=> rx_flag_three)
        else $error("rx flag lost without clear");
    cover property (rx_flag_three);
    cover property (tx_flag_three);
    cover property (addr_match);
endmodule
`default_nettype wire

/* File: bench/iam_regs_tb_top.sv */
/*
 * bench top for iam_regs: avalon-mm tasks, frames via the bus model.
 * assumes rtl/ is on the include path.
 */
`timescale 1ns/100ps
`default_nettype none
`include "iam_defs.vh"
module iam_regs_tb_top;
    logic        mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, rdat;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [1:0]  rrsp;
    wire  [31:0] avs_readdata;
    wire  [1:0]  avs_response;
    wire  [9:0]  addr_in, target_tx_addr;
    wire         avs_waitrequest, addr_strobe, frame_end, rx_byte_done, tx_buf_empty;
    wire         addr_match, target_tx_valid, module_soft_reset, rx_flag_three;
    wire         tx_flag_three, irq;
    int          err_total = 0, check_count = 0, cyc = 0;
    logic [7:0]  rofs [6] = '{`IAM_OFS_CTRL, `IAM_OFS_OWN3, `IAM_OFS_RXADDR, `IAM_OFS_MASK,
                              `IAM_OFS_TARGET, `IAM_OFS_INT_STAT};
    logic [31:0] rval [6] = '{32'h1, 32'h0, 32'h0, 32'h3FF, 32'h0, 32'h0};
    logic [3:0]  fc [4] = '{4'h0, 4'h2, 4'h2, 4'h8};
    logic [9:0]  fa [4] = '{10'h3D7, 10'h3D7, 10'h056, 10'h055};
    logic        ft [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [2:0]  fe [4] = '{3'h5, 3'h0, 3'h6, 3'h0};
    always #10 mclk = ~mclk;
    iam_regs i_dut (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .addr_strobe,
        .addr_in, .frame_end, .rx_byte_done, .tx_buf_empty, .addr_match, .target_tx_addr,
        .target_tx_valid, .module_soft_reset, .rx_flag_three, .tx_flag_three, .irq);
    iam_bus_model i_bus (.mclk, .addr_strobe, .addr_in, .rx_byte_done, .tx_buf_empty,
        .frame_end);
    task automatic end_sim;
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // sampled right after the edge, before that edge's updates land
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk) begin avs_read <= !w; avs_write <= w; avs_address <= a;
            avs_writedata <= d; end
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        rrsp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            end_sim;
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        for (int i=0; i<6; i++) rd(rofs[i], rval[i]);
        chk({31'h0, module_soft_reset}, 32'h1);
        wr(`IAM_OFS_CTRL, 32'h0);
        wr(`IAM_OFS_OWN3, 32'h455);
        wr(`IAM_OFS_MASK, 32'h3FC);
        chk({31'h0, module_soft_reset}, 32'h0);
        rd(`IAM_OFS_OWN3, 32'h0);
        rd(`IAM_OFS_MASK, 32'h3FF);
        wr(`IAM_OFS_CTRL, 32'h1);
        wr(`IAM_OFS_OWN3, 32'hFC55);
        wr(`IAM_OFS_MASK, 32'hFFFFF3FC);
        rd(`IAM_OFS_OWN3, 32'h455);
        rd(`IAM_OFS_MASK, 32'h3FC);
        wr(`IAM_OFS_INT_EN, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(`IAM_OFS_CTRL, {28'h0, fc[i]});
            i_bus.frame(fa[i], ft[i]);
            rd(`IAM_OFS_RXADDR, {22'h0, fa[i]});
            rd(`IAM_OFS_INT_STAT, {29'h0, fe[i]});
            chk({28'h0, irq, rx_flag_three, tx_flag_three, target_tx_valid},
                {28'h0, fe[i][0], fe[i][0], fe[i][1], fc[i][3]});
            wr(`IAM_OFS_INT_CLR, 32'h7);
            @(negedge mclk);
            chk({29'h0, irq, rx_flag_three, tx_flag_three}, 32'h0);
        end
        wr(`IAM_OFS_CTRL, 32'h1);
        wr(`IAM_OFS_OWN3, 32'h055);
        wr(`IAM_OFS_CTRL, 32'h0);
        i_bus.frame(10'h055, 1'b0);
        rd(`IAM_OFS_INT_STAT, 32'h0);
        wr(`IAM_OFS_TARGET, 32'hFFFF);
        rd(`IAM_OFS_TARGET, 32'h3FF);
        chk({22'h0, target_tx_addr}, 32'h07F);
        wr(`IAM_OFS_CTRL, 32'h4);
        @(negedge mclk);
        chk({22'h0, target_tx_addr}, 32'h3FF);
        rd(8'h40, 32'h0);
        chk({30'h0, rrsp}, 32'h3);
        end_sim;
    end
endmodule
bind iam_regs iam_regs_chk u_chk (.mclk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .avs_response, .rx_byte_done, .tx_buf_empty,
    .addr_match, .target_tx_valid, .module_soft_reset, .rx_flag_three, .tx_flag_three);
`default_nettype wire

/* File: rtl/iam_addr_cmp.v */
/*
 * masked comparison of a bus address with one own address.
 * assumes inputs are on the same clock; purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none

module iam_addr_cmp (
    input  wire [9:0] bus_addr,
    input  wire [9:0] own_addr,
    input  wire [9:0] mask,
    input  wire       enable,
    input  wire       ten_bit,
    output wire       hit
);
    wire [9:0] width_mask;
    wire [9:0] diff;

    assign width_mask = ten_bit ? 10'h3FF : 10'h07F;
    assign diff       = (bus_addr ^ own_addr) & mask & width_mask;
    assign hit        = enable & (diff == 10'h000);
endmodule

`default_nettype wire

/* File: rtl/iam_defs.vh */
/*
 * shared constants for the i2c address match register block: register
 * offsets, field positions, reset values, interrupt bit layout.
 * assumes a 32-bit avalon-mm slave with word addresses in bytes.
 */
`ifndef IAM_DEFS_VH
`define IAM_DEFS_VH

`define IAM_OFS_CTRL        8'h00
`define IAM_OFS_OWN3        8'h04
`define IAM_OFS_RXADDR      8'h08
`define IAM_OFS_MASK        8'h0C
`define IAM_OFS_TARGET      8'h10
`define IAM_OFS_STATUS      8'h14
`define IAM_OFS_INT_STAT    8'h18
`define IAM_OFS_INT_EN      8'h1C
`define IAM_OFS_INT_CLR     8'h20

`define IAM_CTRL_SWRST      0
`define IAM_CTRL_OWN10      1
`define IAM_CTRL_SLV10      2
`define IAM_CTRL_MASTER     3

`define IAM_OWN_EN_BIT      10
`define IAM_ADDR_W          10
`define IAM_OWN3_RST        11'h000
`define IAM_RXADDR_RST      10'h000
`define IAM_MASK_RST        10'h3FF
`define IAM_TARGET_RST      10'h000
`define IAM_CTRL_RST        4'h1

`define IAM_INT_RX3         0
`define IAM_INT_TX3         1
`define IAM_INT_MATCH       2
`define IAM_INT_W           3

`endif

/* File: rtl/iam_regs.v */
/*
 * i2c address match register block: third own address with enable,
 * received address capture, address mask, target address, flag three
 * generation and an interrupt group, behind an avalon-mm slave.
 * assumes the shift engine is on mclk and pulses its event inputs
 * for one cycle; no bus pins are sampled here.
 */
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "iam_defs.vh"

module iam_regs (
    input  wire        mclk,
    input  wire        rst,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    output reg  [1:0]  avs_response,
    input  wire        addr_strobe,
    input  wire [9:0]  addr_in,
    input  wire        frame_end,
    input  wire        rx_byte_done,
    input  wire        tx_buf_empty,
    output wire        addr_match,
    output wire [9:0]  target_tx_addr,
    output wire        target_tx_valid,
    output wire        module_soft_reset,
    output wire        rx_flag_three,
    output wire        tx_flag_three,
    output wire        irq
);
    localparam ST_IDLE = 2'b01;
    localparam ST_ACK  = 2'b10;

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [3:0]  ctrl_reg;
    reg         own_addr_enable_reg;
    reg  [9:0]  own_addr_three_value_reg;
    reg  [9:0]  received_addr_value_reg;
    reg  [9:0]  addr_mask_value_reg;
    reg  [9:0]  target_addr_value_reg;
    reg         frame_hit_reg;
    reg  [2:0]  int_stat_reg;
    reg  [2:0]  int_en_reg;
    reg  [2:0]  int_set;
    reg  [31:0] rdata_next;
    reg  [1:0]  resp_next;
    reg         mapped;
    wire        wr_go;
    wire        rd_go;
    wire        cmp_hit;
    wire        slave_mode;
    wire [10:0] own3_rst;
    wire [15:0] own3_wr;
    wire [15:0] mask_wr;
    wire [15:0] target_wr;

    // merge byte lanes of a write into the old value of a 16-bit register
    function [15:0] merge16;
        input [15:0] old_val;
        input [31:0] wdata;
        input [3:0]  be;
        begin
            merge16 = {be[1] ? wdata[15:8] : old_val[15:8],
                       be[0] ? wdata[7:0]  : old_val[7:0]};
        end
    endfunction

    // merged write images; only the documented field bits are kept below
    assign own3_rst  = `IAM_OWN3_RST;
    assign own3_wr   = merge16({5'h00, own_addr_enable_reg, own_addr_three_value_reg},
                               avs_writedata, avs_byteenable);
    assign mask_wr   = merge16({6'h00, addr_mask_value_reg}, avs_writedata, avs_byteenable);
    assign target_wr = merge16({6'h00, target_addr_value_reg}, avs_writedata, avs_byteenable);

    // one wait cycle: request taken in idle, answered in ack
    assign avs_waitrequest = (avs_read | avs_write) & (state_reg != ST_ACK);
    assign wr_go           = avs_write & (state_reg == ST_ACK);
    assign rd_go           = avs_read & (state_reg == ST_ACK);

    always @* begin
        state_next = ST_IDLE;
        case (state_reg)
            ST_IDLE: begin
                if (avs_read | avs_write) begin
                    state_next = ST_ACK;
                end
            end
            ST_ACK: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    assign module_soft_reset = ctrl_reg[`IAM_CTRL_SWRST];
    assign slave_mode        = ~ctrl_reg[`IAM_CTRL_MASTER];

    iam_addr_cmp u_cmp (
        .bus_addr (addr_in),
        .own_addr (own_addr_three_value_reg),
        .mask     (addr_mask_value_reg),
        .enable   (own_addr_enable_reg),
        .ten_bit  (ctrl_reg[`IAM_CTRL_OWN10]),
        .hit      (cmp_hit)
    );

    iam_target_fmt u_tgt (
        .target   (target_addr_value_reg),
        .ten_bit  (ctrl_reg[`IAM_CTRL_SLV10]),
        .master   (ctrl_reg[`IAM_CTRL_MASTER]),
        .tx_addr  (target_tx_addr),
        .tx_valid (target_tx_valid)
    );

    // a disabled or reset unit never claims an address
    assign addr_match = cmp_hit & slave_mode & ~module_soft_reset;

    // flag three follows the frame that this address opened
    assign rx_flag_three = int_stat_reg[`IAM_INT_RX3];
    assign tx_flag_three = int_stat_reg[`IAM_INT_TX3];

    always @* begin
        int_set = 3'h0;
        int_set[`IAM_INT_RX3]   = frame_hit_reg & slave_mode & rx_byte_done;
        int_set[`IAM_INT_TX3]   = frame_hit_reg & slave_mode & tx_buf_empty;
        int_set[`IAM_INT_MATCH] = addr_strobe & addr_match;
    end

    assign irq = |(int_stat_reg & int_en_reg);

    always @(posedge mclk) begin
        if (rst) begin
            frame_hit_reg           <= 1'b0;
            received_addr_value_reg <= `IAM_RXADDR_RST;
        end else begin
            if (addr_strobe) begin
                received_addr_value_reg <= addr_in;
                frame_hit_reg           <= addr_match;
            end else if (frame_end | module_soft_reset) begin
                frame_hit_reg <= 1'b0;
            end
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            state_reg                <= ST_IDLE;
            ctrl_reg                 <= `IAM_CTRL_RST;
            own_addr_enable_reg      <= own3_rst[`IAM_OWN_EN_BIT];
            own_addr_three_value_reg <= own3_rst[9:0];
            addr_mask_value_reg      <= `IAM_MASK_RST;
            target_addr_value_reg    <= `IAM_TARGET_RST;
            int_stat_reg             <= 3'h0;
            int_en_reg               <= 3'h0;
        end else begin
            state_reg <= state_next;
            if (wr_go && avs_address == `IAM_OFS_CTRL && avs_byteenable[0]) begin
                ctrl_reg <= avs_writedata[3:0];
            end
            // own address three and mask are frozen unless the unit is held in soft reset
            if (wr_go && module_soft_reset) begin
                if (avs_address == `IAM_OFS_OWN3) begin
                    own_addr_enable_reg      <= own3_wr[`IAM_OWN_EN_BIT];
                    own_addr_three_value_reg <= own3_wr[9:0];
                end
                if (avs_address == `IAM_OFS_MASK) begin
                    addr_mask_value_reg <= mask_wr[9:0];
                end
            end
            if (wr_go && avs_address == `IAM_OFS_TARGET) begin
                target_addr_value_reg <= target_wr[9:0];
            end
            if (wr_go && avs_address == `IAM_OFS_INT_EN && avs_byteenable[0]) begin
                int_en_reg <= avs_writedata[2:0];
            end
            // set wins over a clear in the same cycle
            if (wr_go && avs_address == `IAM_OFS_INT_CLR && avs_byteenable[0]) begin
                int_stat_reg <= (int_stat_reg & ~avs_writedata[2:0]) | int_set;
            end else begin
                int_stat_reg <= int_stat_reg | int_set;
            end
        end
    end

    always @* begin
        rdata_next = 32'h0000_0000;
        mapped     = 1'b1;
        case (avs_address)
            `IAM_OFS_CTRL:     rdata_next = {28'h0, ctrl_reg};
            `IAM_OFS_OWN3:     rdata_next = {21'h0, own_addr_enable_reg,
                                             own_addr_three_value_reg};
            `IAM_OFS_RXADDR:   rdata_next = {22'h0, received_addr_value_reg};
            `IAM_OFS_MASK:     rdata_next = {22'h0, addr_mask_value_reg};
            `IAM_OFS_TARGET:   rdata_next = {22'h0, target_addr_value_reg};
            `IAM_OFS_STATUS:   rdata_next = {30'h0, frame_hit_reg, addr_match};
            `IAM_OFS_INT_STAT: rdata_next = {29'h0, int_stat_reg};
            `IAM_OFS_INT_EN:   rdata_next = {29'h0, int_en_reg};
            `IAM_OFS_INT_CLR:  rdata_next = 32'h0000_0000;
            default:           mapped     = 1'b0;
        endcase
        resp_next = mapped ? 2'b00 : 2'b11;
    end

    // read data registered in the wait cycle so it stands at the release edge
    always @(posedge mclk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
        end else begin
            if (state_reg == ST_IDLE && (avs_read | avs_write)) begin
                avs_readdata <= avs_read ? rdata_next : 32'h0000_0000;
                avs_response <= resp_next;
            end
        end
    end
endmodule

`default_nettype wire

/* File: rtl/iam_target_fmt.v */
/*
 * formats the target address for the master side of the shift engine.
 * assumes the shift engine only samples it while master mode is set.
 */
`timescale 1ns/100ps
`default_nettype none

module iam_target_fmt (
    input  wire [9:0] target,
    input  wire       ten_bit,
    input  wire       master,
    output wire [9:0] tx_addr,
    output wire       tx_valid
);
    // upper bits forced low in 7-bit mode so the engine never sends them
    assign tx_addr  = ten_bit ? target : {3'h0, target[6:0]};
    assign tx_valid = master;
endmodule

`default_nettype wire
